// ==== logic/cbg_link_if.sv ====
// Carrier between the controller core and its link-side helpers.
// Assumes all members are on pclk.
`timescale 1ns/1ps
interface cbg_link_if;
  logic       rx_en;
  logic [7:0] rx_byte;
  logic       rx_byte_stb;
  logic       rx_blk_end;
  logic [2:0] wk_en;
  logic [2:0] wk_evt;
  logic       wk_present;
  logic       wk_wake;
  modport rx   (input rx_en, output rx_byte, rx_byte_stb, rx_blk_end);
  modport rx_c (output rx_en, input rx_byte, rx_byte_stb, rx_blk_end);
  modport wk   (input wk_en, output wk_evt, wk_present, wk_wake);
  modport wk_c (output wk_en, input wk_evt, wk_present, wk_wake);
endinterface

// ==== logic/cbg_pkg.sv ====
// Shared constants for the block-gap / wakeup controller.
// Assumes APB byte addresses in the low eight address bits.
package cbg_pkg;
  // Register byte addresses
  localparam logic [7:0] A_XFER = 8'h00;
  localparam logic [7:0] A_BGC  = 8'h04;
  localparam logic [7:0] A_STS  = 8'h08;
  localparam logic [7:0] A_STEN = 8'h0C;
  localparam logic [7:0] A_WAKE = 8'h10;
  localparam logic [7:0] A_PST  = 8'h14;
  // Transfer control fields
  localparam int X_START  = 0;
  localparam int X_DDMA   = 1;
  localparam int X_CNT_LO = 16;
  localparam int X_CNT_W  = 16;
  // Configuration bits inside the transfer register, above start
  localparam int C_DDMA = 0;
  localparam int C_CRW  = 1;
  localparam int C_CSR  = 2;
  // Block gap control fields
  localparam int BG_STOP = 0;
  localparam int BG_CONT = 1;
  // Status bits (write one to clear)
  localparam int S_TC   = 0;
  localparam int S_BGE  = 1;
  localparam int S_CINT = 2;
  localparam int S_INS  = 3;
  localparam int S_REM  = 4;
  localparam int S_W    = 5;
  localparam logic [4:0] STEN_RST = 5'h1F;
  // Present state fields
  localparam int P_DAT  = 0;
  localparam int P_RD   = 1;
  localparam int P_RW   = 2;
  localparam int P_PRES = 3;
  localparam int P_RSR  = 4;
  localparam int P_WSR  = 5;
  // Wakeup enables
  localparam int W_CINT = 0;
  localparam int W_INS  = 1;
  localparam int W_REM  = 2;
  // Host capabilities and link framing
  localparam logic       HOST_SR   = 1'b1;
  localparam logic       HOST_RW   = 1'b1;
  localparam logic [2:0] BLK_BYTES = 3'h4;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  typedef enum logic [2:0] {
    CBG_IDLE = 3'b000,
    CBG_RUN  = 3'b001,
    CBG_GAPD = 3'b011,
    CBG_HALT = 3'b010,
    CBG_LSTD = 3'b101
  } cbg_state_t;
endpackage

// ==== logic/cbg_rx.sv ====
// Card read-data receiver: samples card_clk and card_dat on pclk.
// Assumes a frame of start bit 0, BLK_BYTES bytes MSB first, end bit.
`timescale 1ns/1ps
module cbg_rx (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Card pins
  input  wire logic card_clk,
  input  wire logic card_dat,
  // Core side
  cbg_link_if.rx    lk
);
  logic [1:0] cs;
  logic [1:0] ds;
  logic       cprev;
  logic       busy;
  logic [2:0] bitc;
  logic [2:0] bytec;
  logic [7:0] sh;
  wire        rise = cs[1] & ~cprev & lk.rx_en;
  wire [7:0]  next_sh = {sh[6:0], ds[1]};

  // Two-stage synchronisers; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs    <= 2'h0;
      ds    <= 2'h3;
      cprev <= 1'b0;
    end else begin
      cs    <= {cs[0], card_clk};
      ds    <= {ds[0], card_dat};
      cprev <= cs[1];
    end
  end

  // Framing: hunt start bit, shift bytes, swallow end bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy           <= 1'b0;
      bitc           <= 3'h0;
      bytec          <= 3'h0;
      sh             <= 8'h00;
      lk.rx_byte     <= 8'h00;
      lk.rx_byte_stb <= 1'b0;
      lk.rx_blk_end  <= 1'b0;
    end else begin
      lk.rx_byte_stb <= 1'b0;
      lk.rx_blk_end  <= 1'b0;
      if (rise) begin
        if (!busy) begin
          busy  <= ~ds[1];
          bitc  <= 3'h0;
          bytec <= 3'h0;
        end else if (bytec == cbg_pkg::BLK_BYTES) begin
          busy          <= 1'b0;
          lk.rx_blk_end <= 1'b1;
        end else begin
          sh   <= next_sh;
          bitc <= bitc + 3'h1;
          if (bitc == cbg_pkg::LAST_BIT) begin
            lk.rx_byte     <= next_sh;
            lk.rx_byte_stb <= 1'b1;
            bytec          <= bytec + 3'h1;
          end
        end
      end
    end
  end
endmodule

// ==== logic/cbg_top.sv ====
// Card host block-gap stop/continue, read path and wakeup control.
// Assumes an APB master on pclk and a card driving card_clk/card_dat.
//
// How it works
// - Three wakeup sources, each separately enabled
// - Read suspend needs read wait, never descriptor DMA
// - Gap event, transfer complete: write-one clears
// - Read suspend also needs card read wait
// - Stop gives complete; gap event only mid-transfer
// - Pause at gap by read wait or clock stop
// - Status bits owned by hardware, control by software
// - Stop ends block, drops data active, gap event
// - Drain done: drop read active, raise complete
// - Stop at last block ignored, normal completion
// - Continue releases wait, sets actives, self-clears
// - Last block: data inactive, drain, then complete
`timescale 1ns/1ps
module cbg_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Card link
  input  wire logic        card_clk,
  input  wire logic        card_dat,
  input  wire logic        card_int,
  input  wire logic        card_detect,
  output logic             card_clk_stop,
  output logic             read_wait,
  output logic             wake,
  // System memory stream
  output logic             mem_valid,
  output logic      [7:0]  mem_data,
  input  wire logic        mem_ready
);
  cbg_pkg::cbg_state_t state;
  cbg_pkg::cbg_state_t next_state;
  logic [2:0]  cfg;
  logic [15:0] blk_left;
  logic        stop_req;
  logic        cont_req;
  logic [4:0]  sts;
  logic [4:0]  sten;
  logic [2:0]  wake_en;
  logic        dat_act;
  logic        rd_act;

  cbg_link_if lk();

  cbg_rx u_rx (
    .clk      (pclk),
    .rst_n    (presetn),
    .card_clk (card_clk),
    .card_dat (card_dat),
    .lk       (lk.rx)
  );

  cbg_wake u_wk (
    .clk         (pclk),
    .rst_n       (presetn),
    .card_int    (card_int),
    .card_detect (card_detect),
    .lk          (lk.wk)
  );

  // Bus decode
  wire setup  = psel & ~penable;
  wire wr     = psel & penable & pready & pwrite;
  wire hit_x  = paddr == cbg_pkg::A_XFER;
  wire hit_bg = paddr == cbg_pkg::A_BGC;
  wire hit_st = paddr == cbg_pkg::A_STS;
  wire hit_se = paddr == cbg_pkg::A_STEN;
  wire hit_wk = paddr == cbg_pkg::A_WAKE;
  wire hit_ps = paddr == cbg_pkg::A_PST;
  wire mapped = hit_x | hit_bg | hit_st | hit_se | hit_wk | hit_ps;

  // Capability view: read suspend needs card read wait, no descriptor DMA
  wire wr_sr_ok = cbg_pkg::HOST_SR & cfg[cbg_pkg::C_CSR];
  wire rd_sr_ok = wr_sr_ok & cbg_pkg::HOST_RW & cfg[cbg_pkg::C_CRW]
                  & ~cfg[cbg_pkg::C_DDMA];
  wire use_rw   = cbg_pkg::HOST_RW & cfg[cbg_pkg::C_CRW];

  // Read data views
  wire [31:0] rd_x = (32'(blk_left) << cbg_pkg::X_CNT_LO) | (32'(cfg) << cbg_pkg::X_DDMA);
  wire [31:0] rd_bg = (32'(stop_req) << cbg_pkg::BG_STOP) | (32'(cont_req) << cbg_pkg::BG_CONT);
  wire [31:0] rd_ps = (32'(dat_act) << cbg_pkg::P_DAT) | (32'(rd_act) << cbg_pkg::P_RD)
                    | (32'(read_wait) << cbg_pkg::P_RW)
                    | (32'(lk.wk_present) << cbg_pkg::P_PRES)
                    | (32'(rd_sr_ok) << cbg_pkg::P_RSR) | (32'(wr_sr_ok) << cbg_pkg::P_WSR)
                    | (32'(blk_left) << cbg_pkg::X_CNT_LO);
  wire [31:0] rd_mux = hit_x  ? rd_x :
                       hit_bg ? rd_bg :
                       hit_st ? 32'(sts) :
                       hit_se ? 32'(sten) :
                       hit_wk ? 32'(wake_en) :
                       hit_ps ? rd_ps : 32'h0000_0000;

  // Transfer events
  wire [15:0] new_cnt = pwdata[cbg_pkg::X_CNT_LO +: cbg_pkg::X_CNT_W];
  wire start    = wr & hit_x & pwdata[cbg_pkg::X_START] & (state == cbg_pkg::CBG_IDLE)
                  & (new_cnt != 16'h0000);
  wire blk_end  = (state == cbg_pkg::CBG_RUN) & lk.rx_blk_end;
  wire last     = blk_left == 16'h0001;
  wire gap_stop = blk_end & stop_req & ~last;
  wire cont_wr  = wr & hit_bg & pwdata[cbg_pkg::BG_CONT] & ~pwdata[cbg_pkg::BG_STOP];
  wire cont_ok  = cont_wr & (state == cbg_pkg::CBG_HALT);
  wire drained  = ~mem_valid & ~lk.rx_byte_stb;
  wire tc_set   = ((state == cbg_pkg::CBG_GAPD) | (state == cbg_pkg::CBG_LSTD)) & drained;

  // Status set sources in status bit order
  wire [4:0] sts_set;
  assign sts_set[cbg_pkg::S_TC]   = tc_set;
  assign sts_set[cbg_pkg::S_BGE]  = gap_stop;
  assign sts_set[cbg_pkg::S_CINT] = lk.wk_evt[cbg_pkg::W_CINT];
  assign sts_set[cbg_pkg::S_INS]  = lk.wk_evt[cbg_pkg::W_INS];
  assign sts_set[cbg_pkg::S_REM]  = lk.wk_evt[cbg_pkg::W_REM];
  assign lk.rx_en = state == cbg_pkg::CBG_RUN;
  assign lk.wk_en = wake_en;

  // Sequencer for stop at gap, continue and final drain
  always_comb begin
    next_state = state;
    unique case (state)
      cbg_pkg::CBG_IDLE: if (start) next_state = cbg_pkg::CBG_RUN;
      cbg_pkg::CBG_RUN: begin
        if (blk_end && last) next_state = cbg_pkg::CBG_LSTD;
        else if (gap_stop) next_state = cbg_pkg::CBG_GAPD;
      end
      cbg_pkg::CBG_GAPD: if (drained) next_state = cbg_pkg::CBG_HALT;
      cbg_pkg::CBG_HALT: if (cont_ok) next_state = cbg_pkg::CBG_RUN;
      cbg_pkg::CBG_LSTD: if (drained) next_state = cbg_pkg::CBG_IDLE;
      default: next_state = cbg_pkg::CBG_IDLE;
    endcase
  end

  // State and hardware-owned status follow the next state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= cbg_pkg::CBG_IDLE;
      dat_act       <= 1'b0;
      rd_act        <= 1'b0;
      read_wait     <= 1'b0;
      card_clk_stop <= 1'b0;
    end else begin
      state         <= next_state;
      dat_act       <= next_state == cbg_pkg::CBG_RUN;
      rd_act        <= (next_state != cbg_pkg::CBG_IDLE)
                       & (next_state != cbg_pkg::CBG_HALT);
      read_wait     <= (next_state == cbg_pkg::CBG_HALT) & use_rw;
      card_clk_stop <= (next_state == cbg_pkg::CBG_HALT) & ~use_rw;
    end
  end

  // Software control registers; continue lives one cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg      <= 3'h0;
      blk_left <= 16'h0000;
      stop_req <= 1'b0;
      cont_req <= 1'b0;
      sten     <= cbg_pkg::STEN_RST;
      wake_en  <= 3'h0;
    end else begin
      cont_req <= cont_wr;
      if (wr && hit_x) cfg <= pwdata[cbg_pkg::X_DDMA +: 3];
      if (start) blk_left <= new_cnt;
      else if (blk_end) blk_left <= blk_left - 16'h0001;
      if (wr && hit_bg) stop_req <= pwdata[cbg_pkg::BG_STOP];
      if (wr && hit_se) sten <= pwdata[4:0];
      if (wr && hit_wk) wake_en <= pwdata[2:0];
    end
  end

  // Sticky status: a set in the clearing cycle wins
  wire [4:0] next_sts;
  genvar gi;
  generate
    for (gi = 0; gi < cbg_pkg::S_W; gi++) begin : g_sts
      wire clr = wr & hit_st & pwdata[gi];
      assign next_sts[gi] = (sts_set[gi] & sten[gi]) | (sts[gi] & ~clr);
    end
  endgenerate

  // One process owns every status bit, so no bit has two writers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sts <= 5'h00;
    else sts <= next_sts;
  end

  // Read data toward memory; at most one byte waits here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_valid <= 1'b0;
      mem_data  <= 8'h00;
    end else if (lk.rx_byte_stb) begin
      mem_valid <= 1'b1;
      mem_data  <= lk.rx_byte;
    end else if (mem_ready) begin
      mem_valid <= 1'b0;
    end
  end

  // APB answer: one wait-free access phase, data registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      wake    <= 1'b0;
    end else begin
      pready  <= setup & ~pready;
      pslverr <= setup & ~mapped;
      if (setup) prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      wake    <= lk.wk_wake;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_gap_stop;
    state == cbg_pkg::CBG_RUN && lk.rx_blk_end && stop_req && blk_left != 16'h0001;
  endsequence
  sequence s_last_blk;
    state == cbg_pkg::CBG_RUN && lk.rx_blk_end && blk_left == 16'h0001;
  endsequence

  a_gap_event: assert property (s_gap_stop |=> sts[cbg_pkg::S_BGE] && !dat_act && rd_act)
    else $error("gap stop missed event or status");
  a_last_nogap: assert property (s_last_blk ##1 !sts[cbg_pkg::S_BGE] |=>
    !sts[cbg_pkg::S_BGE] && !dat_act)
    else $error("gap event after last block");
  a_drain_done: assert property (state == cbg_pkg::CBG_GAPD && drained |=>
    !rd_act && sts[cbg_pkg::S_TC] && state == cbg_pkg::CBG_HALT)
    else $error("drain end not reported");
  a_last_done: assert property (s_last_blk ##1 (drained [*2]) |=>
    state == cbg_pkg::CBG_IDLE && !rd_act)
    else $error("last block drain not finished");
  a_tc_clear: assert property (wr && hit_st && pwdata[cbg_pkg::S_TC] && !tc_set |=>
    !sts[cbg_pkg::S_TC])
    else $error("complete not cleared by one");
  a_zero_keep: assert property (wr && hit_st && !pwdata[cbg_pkg::S_BGE] && sts[cbg_pkg::S_BGE]
    |=> sts[cbg_pkg::S_BGE])
    else $error("gap event lost on zero write");
  a_cont_go: assert property (state == cbg_pkg::CBG_HALT && cont_wr |=>
    dat_act && rd_act && !read_wait && !card_clk_stop ##1 !cont_req)
    else $error("continue not accepted");
  a_cont_drop: assert property (cont_wr && state != cbg_pkg::CBG_HALT |=>
    $stable(dat_act) && $stable(rd_act) ##1 !cont_req)
    else $error("stray continue changed status");
  a_halt_pause: assert property ($rose(state == cbg_pkg::CBG_HALT) |->
    (read_wait ^ card_clk_stop) && read_wait == use_rw)
    else $error("halt without pause");
  a_wake_gate: assert property (wake |-> $past(lk.wk_en, 2) != 3'h0)
    else $error("wake without enable");

  // Pause levels and activity flags against the sequencer position
  sequence s_halted;
    state == cbg_pkg::CBG_HALT;
  endsequence

  a_halt_quiet: assert property (s_halted |-> !dat_act && !rd_act)
    else $error("halted with transfer still active");
  a_halt_pauses: assert property (s_halted |-> read_wait || card_clk_stop)
    else $error("halted with card bus not paused");
  a_pause_only: assert property (read_wait || card_clk_stop |-> s_halted)
    else $error("card bus paused outside a halt");
  a_run_active: assert property (state == cbg_pkg::CBG_RUN |-> dat_act && rd_act)
    else $error("running without active flags");
  a_idle_quiet: assert property (state == cbg_pkg::CBG_IDLE |-> !dat_act && !rd_act)
    else $error("idle with active flags");
  a_gap_cause: assert property ($rose(sts[cbg_pkg::S_BGE]) |-> $past(gap_stop))
    else $error("gap event without gap stop");
  a_tc_drained: assert property ($rose(sts[cbg_pkg::S_TC]) |-> !rd_act && !mem_valid)
    else $error("complete raised with data pending");
  a_cont_clear: assert property (cont_req |=> !cont_req)
    else $error("continue request did not clear");
  a_wake_source: assert property (lk.wk_wake |-> (lk.wk_evt & $past(lk.wk_en)) != 3'h0)
    else $error("wake without an enabled source");
  a_count_step: assert property (blk_end |=> blk_left == $past(blk_left) - 16'h0001)
    else $error("block count did not step");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("error flag outside access phase");
endmodule

// ==== logic/cbg_wake.sv ====
// Wakeup source detector: card interrupt, insertion, removal.
// Assumes card_int and card_detect are asynchronous, active high.
`timescale 1ns/1ps
module cbg_wake (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Card pins
  input  wire logic card_int,
  input  wire logic card_detect,
  // Core side
  cbg_link_if.wk    lk
);
  logic [1:0] ci;
  logic [1:0] cd;
  logic       cdprev;
  wire  [2:0] evt;

  // Sources in wakeup-enable bit order
  assign evt[cbg_pkg::W_CINT] = ci[1];
  assign evt[cbg_pkg::W_INS]  = cd[1] & ~cdprev;
  assign evt[cbg_pkg::W_REM]  = ~cd[1] & cdprev;

  // Synchronise, find detect edges, gate wake by per-source enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ci            <= 2'h0;
      cd            <= 2'h0;
      cdprev        <= 1'b0;
      lk.wk_evt     <= 3'h0;
      lk.wk_present <= 1'b0;
      lk.wk_wake    <= 1'b0;
    end else begin
      ci            <= {ci[0], card_int};
      cd            <= {cd[0], card_detect};
      cdprev        <= cd[1];
      lk.wk_evt     <= evt;
      lk.wk_present <= cd[1];
      lk.wk_wake    <= |(evt & lk.wk_en);
    end
  end
endmodule

// ==== test/cbg_card_model.sv ====
// Card model: sends read blocks on the card bus and drives detect/int.
// Assumes the host pause (read wait or clock stop) arrives as one level.
`timescale 1ns/1ps
module cbg_card_model (
  // Host pause
  input  wire logic pause,
  // Card pins
  output logic      card_clk,
  output logic      card_dat,
  output logic      card_int,
  output logic      card_detect
);
  // Clock still and data parked outside frames
  initial begin
    card_clk = 1'b0;
    card_dat = 1'b1;
    card_int = 1'b0;
    card_detect = 1'b0;
  end

  // One block: start bit, four bytes MSB first, end bit
  task automatic send_block(input logic [31:0] d);
    logic [33:0] f;
    f = {1'b0, d, 1'b1};
    wait (pause === 1'b0);
    for (int i = 33; i >= 0; i--) begin
      card_dat = f[i];
      #160 card_clk = 1'b1;
      #160 card_clk = 1'b0;
    end
    card_dat = ~f[0]; // Released line shows no stale value
  endtask

  // Presence and interrupt levels
  task automatic set_pins(input logic i, input logic c);
    card_int = i;
    card_detect = c;
  endtask
endmodule

// ==== test/cbg_tb_top.sv ====
// Bench for cbg_top: APB tasks, read block-gap flows and wakeup sources.
// Assumes cbg_pkg and the card model are compiled before this file.
`timescale 1ns/1ps
module cbg_tb_top;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        mem_ready = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, card_clk, card_dat, card_int, card_detect;
  logic        card_clk_stop, read_wait, wake, mem_valid;
  logic [7:0]  mem_data;
  logic [7:0]  rx_q[$];
  int          n_errors = 0;
  int          tests_run = 0;
  int          n_wake = 0;

  cbg_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_clk(card_clk), .card_dat(card_dat),
    .card_int(card_int), .card_detect(card_detect), .card_clk_stop(card_clk_stop),
    .read_wait(read_wait), .wake(wake), .mem_valid(mem_valid),
    .mem_data(mem_data), .mem_ready(mem_ready)
  );
  cbg_card_model card (
    .pause(read_wait | card_clk_stop), .card_clk(card_clk), .card_dat(card_dat),
    .card_int(card_int), .card_detect(card_detect)
  );

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Memory sink and count of cycles with wake high
  always @(posedge pclk) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) rx_q.push_back(mem_data);
    if (wake === 1'b1) n_wake++;
  end

  task automatic check(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      n_errors++;
      $display("unexpected %0t got %h exp %h", $time, g, x);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves after one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    check({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, x);
    check({31'h0, e}, 32'h0);
  endtask

  // Block bytes must leave MSB first
  task automatic blk_chk(input logic [31:0] d);
    if (rx_q.size() < 4) check(32'h0, 32'h1);
    else for (int k = 3; k >= 0; k--) check({24'h0, rx_q.pop_front()}, {24'h0, d[8*k +: 8]});
  endtask

  task automatic xfer_blk(input logic [31:0] d);
    card.send_block(d);
    repeat (12) @(posedge pclk);
  endtask

  // Event 0 card interrupt, 1 insertion, 2 removal
  task automatic fire(input int i);
    if (i == 0) begin
      card.set_pins(1'b1, card_detect);
      repeat (6) @(posedge pclk);
      card.set_pins(1'b0, card_detect);
    end else begin
      card.set_pins(1'b0, i == 1);
    end
    repeat (10) @(posedge pclk);
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: whole run is a few thousand cycles
  initial begin
    #400000;
    n_errors++;
    wrap_up;
  end

  // Main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    int          w0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(cbg_pkg::A_STEN, 32'h1F);
    rd(cbg_pkg::A_WAKE, 32'h0);
    rd(cbg_pkg::A_STS, 32'h0);
    rd(cbg_pkg::A_PST, 32'h0);
    apb(1'b0, 8'h18, 32'h0, q, e);
    check(q, 32'h0);
    check({31'h0, e}, 32'h1);
    // Suspend usability against host and card support
    for (int c = 0; c < 8; c++) begin
      wr(cbg_pkg::A_XFER, {28'h0, 3'(c), 1'b0});
      rd(cbg_pkg::A_PST, {26'h0, cbg_pkg::HOST_SR & c[2], cbg_pkg::HOST_SR & cbg_pkg::HOST_RW
         & c[2] & c[1] & !c[0], 4'h0});
    end
    // Two blocks, no stop
    wr(cbg_pkg::A_XFER, 32'h0002_000D);
    rd(cbg_pkg::A_PST, 32'h0002_0033);
    xfer_blk(32'h81C3_5A0F);
    rd(cbg_pkg::A_PST, 32'h0001_0033);
    xfer_blk(32'h0F5A_C381);
    rd(cbg_pkg::A_STS, 32'h1);
    rd(cbg_pkg::A_PST, 32'h0000_0030);
    blk_chk(32'h81C3_5A0F);
    blk_chk(32'h0F5A_C381);
    wr(cbg_pkg::A_STS, 32'h1);
    wr(cbg_pkg::A_BGC, 32'h2);
    rd(cbg_pkg::A_BGC, 32'h0);
    rd(cbg_pkg::A_PST, 32'h0000_0030);
    rd(cbg_pkg::A_STS, 32'h0);
    // Gap stop with read wait, memory stalled on the last byte
    wr(cbg_pkg::A_XFER, 32'h0002_000D);
    wr(cbg_pkg::A_BGC, 32'h1);
    fork
      card.send_block(32'hE7_18_3C_C3);
      begin
        while (rx_q.size() < 3) @(posedge pclk);
        mem_ready <= 1'b0;
      end
    join
    repeat (12) @(posedge pclk);
    rd(cbg_pkg::A_STS, 32'h2);
    rd(cbg_pkg::A_PST, 32'h0001_0032);
    check({31'h0, read_wait}, 32'h0);
    mem_ready <= 1'b1;
    repeat (6) @(posedge pclk);
    rd(cbg_pkg::A_STS, 32'h3);
    rd(cbg_pkg::A_PST, 32'h0001_0034);
    check({30'h0, read_wait, card_clk_stop}, 32'h2);
    wr(cbg_pkg::A_STS, 32'h0);
    rd(cbg_pkg::A_STS, 32'h3);
    wr(cbg_pkg::A_STS, 32'h3);
    rd(cbg_pkg::A_STS, 32'h0);
    wr(cbg_pkg::A_BGC, 32'h2);
    rd(cbg_pkg::A_BGC, 32'h0);
    check({31'h0, read_wait}, 32'h0);
    rd(cbg_pkg::A_PST, 32'h0001_0033);
    xfer_blk(32'h6699_0001);
    rd(cbg_pkg::A_STS, 32'h1);
    blk_chk(32'hE718_3CC3);
    blk_chk(32'h6699_0001);
    wr(cbg_pkg::A_STS, 32'h1);
    // Gap stop without read wait, then stop at the last block
    wr(cbg_pkg::A_XFER, 32'h0002_0009);
    wr(cbg_pkg::A_BGC, 32'h1);
    xfer_blk(32'hF00D_1234);
    rd(cbg_pkg::A_STS, 32'h3);
    check({30'h0, read_wait, card_clk_stop}, 32'h1);
    wr(cbg_pkg::A_STS, 32'h3);
    wr(cbg_pkg::A_BGC, 32'h3);
    rd(cbg_pkg::A_PST, 32'h0001_0020);
    check({31'h0, card_clk_stop}, 32'h1);
    wr(cbg_pkg::A_BGC, 32'h2);
    rd(cbg_pkg::A_PST, 32'h0001_0023);
    check({31'h0, card_clk_stop}, 32'h0);
    wr(cbg_pkg::A_BGC, 32'h1);
    xfer_blk(32'h5555_AAAA);
    rd(cbg_pkg::A_STS, 32'h1);
    rd(cbg_pkg::A_PST, 32'h0000_0020);
    check({30'h0, read_wait, card_clk_stop}, 32'h0);
    wr(cbg_pkg::A_BGC, 32'h0);
    wr(cbg_pkg::A_STS, 32'h1);
    blk_chk(32'hF00D_1234);
    blk_chk(32'h5555_AAAA);
    // Wake sources: statuses without enables, then each enable alone
    wr(cbg_pkg::A_WAKE, 32'h0);
    wr(cbg_pkg::A_STEN, 32'h18);
    for (int i = 0; i < 3; i++) fire(i);
    check(32'(n_wake), 32'h0);
    rd(cbg_pkg::A_STS, 32'h18);
    wr(cbg_pkg::A_STS, 32'h1C);
    wr(cbg_pkg::A_STEN, 32'h1F);
    for (int i = 0; i < 3; i++) begin
      wr(cbg_pkg::A_WAKE, 32'h1 << i);
      rd(cbg_pkg::A_WAKE, 32'h1 << i);
      w0 = n_wake;
      fire(i);
      check({31'h0, n_wake > w0}, 32'h1);
      if (i == 1) rd(cbg_pkg::A_PST, 32'h0000_0028);
      rd(cbg_pkg::A_STS, 32'h4 << i);
      wr(cbg_pkg::A_WAKE, 32'h0);
      wr(cbg_pkg::A_STS, 32'h4 << i);
    end
    wrap_up;
  end
endmodule
